// File: core/gpio_ab_pkg.sv
// Shared constants for the port A / port B pin block
package gpio_ab_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int          ADDR_W       = 32;                // AHB address width
  localparam int          DATA_W       = 32;                // AHB data width
  localparam int          REG_IDX_W    = 4;                 // Word index bits decoded
  localparam int          IDX_LSB      = 2;                 // Byte offset bits below index
  localparam int          PA_W         = 4;                 // Port A pin count
  localparam int          PB_W         = 8;                 // Port B pin count

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [31:0] OFS_PA_DIR   = 32'h0000_0000;     // port_a_direction, write only
  localparam logic [31:0] OFS_PA_DATA  = 32'h0000_0004;     // port_a_output_data
  localparam logic [31:0] OFS_PA_LEVEL = 32'h0000_0008;     // port_a_pin_level, read only
  localparam logic [31:0] OFS_PA_PULL  = 32'h0000_000C;     // port_a_pullup_ctrl
  localparam logic [31:0] OFS_PA_DRAIN = 32'h0000_0010;     // port_a_drain_type
  localparam logic [31:0] OFS_PB_DIR   = 32'h0000_0014;     // port_b_direction, write only
  localparam logic [31:0] OFS_PB_DATA  = 32'h0000_0018;     // port_b_output_data
  localparam logic [31:0] OFS_PB_LEVEL = 32'h0000_001C;     // port_b_pin_level, read only
  localparam logic [31:0] OFS_PA_FUNC  = 32'h0000_0020;     // Port A pin function select

  ////////////////////////////////////////////////////////////////////////////
  // Pin function select fields
  localparam int          FN_SHUT_LSB  = 0;                 // shutdown_input0..3_enable
  localparam int          FN_CKIN      = 4;                 // clock_input_select
  localparam int          FN_CKOUT     = 5;                 // clock_output_select
  localparam int          FN_SYNC      = 6;                 // Synchronous serial mode
  localparam int          FN_RXON      = 7;                 // sci_rx_on
  localparam int          FN_TXON      = 8;                 // sci_tx_on
  localparam int          FN_W         = 9;                 // Used width of the register

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and AHB codes
  localparam logic [3:0]  PA_RESET     = 4'h0;              // Port A control bits
  localparam logic [7:0]  PB_RESET     = 8'h00;             // Port B control bits
  localparam logic [8:0]  FN_RESET     = 9'h000;            // Function select
  localparam logic [31:0] RD_ZERO      = 32'h0000_0000;     // Reserved and write-only reads
  localparam logic        RESP_OKAY    = 1'b0;              // Only response given

  // Port A pin function, one per pin
  typedef enum logic [2:0] {
    FUNC_GPIO_IN, FUNC_GPIO_OUT, FUNC_SHUTDOWN, FUNC_SER_CLK_IN, FUNC_SER_CLK_OUT,
    FUNC_SER_RX, FUNC_SER_TX
  } pin_func_t;

endpackage : gpio_ab_pkg

// File: core/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
// Three-stage pin sampler; the held level moves only when stages two and three agree
module pin_sync
  import gpio_ab_pkg::*;
#(
  parameter int W = 8                                     // Number of pins
) (
  // Clock
  input  wire logic         sys_clk,
  // Pins and filtered level
  input  wire logic [W-1:0] pinRaw,
  output logic      [W-1:0] pinLevel
);

  logic [W-1:0] stageOne;                                 // Metastable stage, read by stageTwo only
  logic [W-1:0] stageTwo;                                 // Second stage
  logic [W-1:0] stageThree;                               // Third stage

  ////////////////////////////////////////////////////////////////////////////
  // No reset on purpose: the level then reflects the pins even during reset
  always_ff @(posedge sys_clk) begin
    stageOne   <= pinRaw;
    stageTwo   <= stageOne;
    stageThree <= stageTwo;
  end

  // Accept a bit once the last two stages agree, so one-cycle glitches are dropped
  for (genvar i = 0; i < W; i++) begin : g_filt
    always_ff @(posedge sys_clk) begin
      if (stageTwo[i] == stageThree[i]) begin
        pinLevel[i] <= stageThree[i];
      end
    end
  end

endmodule : pin_sync
`default_nettype wire

// File: core/port_a_mux.sv
`timescale 1ns/10ps
`default_nettype none
// Port A pin function selection by fixed priority per pin
module port_a_mux
  import gpio_ab_pkg::*;
(
  // Clock and reset, for checks only
  input  wire logic            sys_clk,
  input  wire logic            rst,
  // Controls
  input  wire logic [PA_W-1:0] dir,
  input  wire logic [PA_W-1:0] outData,
  input  wire logic [FN_W-1:0] func,
  // Serial channel side
  input  wire logic            serTxData,
  input  wire logic            serClkOut,
  output logic                 serRxData,
  output logic                 serClkIn,
  output logic      [PA_W-1:0] shutdownReq,
  // Pin side
  input  wire logic [PA_W-1:0] pinLevel,
  output logic      [PA_W-1:0] pinIsOut,
  output logic      [PA_W-1:0] pinOutVal
);

  pin_func_t fn [PA_W];                                   // Chosen function per pin

  ////////////////////////////////////////////////////////////////////////////
  // Priority: shutdown input first, then serial use, then plain GPIO
  always_comb begin
    for (int i = 0; i < PA_W; i++) begin
      fn[i] = dir[i] ? FUNC_GPIO_OUT : FUNC_GPIO_IN;
    end
    if (func[FN_CKIN]) begin
      fn[3] = FUNC_SER_CLK_IN;
    end else if (func[FN_SYNC] || func[FN_CKOUT]) begin
      fn[3] = FUNC_SER_CLK_OUT;
    end
    if (func[FN_RXON]) begin
      fn[2] = FUNC_SER_RX;
    end
    if (func[FN_TXON]) begin
      fn[1] = FUNC_SER_TX;
    end
    for (int i = 0; i < PA_W; i++) begin
      if (func[FN_SHUT_LSB + i]) begin
        fn[i] = FUNC_SHUTDOWN;
      end
    end
  end

  // Drive value per function; inputs route the filtered level
  always_comb begin
    for (int i = 0; i < PA_W; i++) begin
      pinIsOut[i]    = (fn[i] == FUNC_GPIO_OUT) || (fn[i] == FUNC_SER_CLK_OUT)
                       || (fn[i] == FUNC_SER_TX);
      pinOutVal[i]   = (fn[i] == FUNC_SER_TX) ? serTxData
                     : (fn[i] == FUNC_SER_CLK_OUT) ? serClkOut : outData[i];
      shutdownReq[i] = (fn[i] == FUNC_SHUTDOWN) && pinLevel[i];
    end
    serRxData = (fn[2] == FUNC_SER_RX) ? pinLevel[2] : 1'b1;  // Idle mark when unused
    serClkIn  = (fn[3] == FUNC_SER_CLK_IN) && pinLevel[3];
  end

  ////////////////////////////////////////////////////////////////////////////
  a_a3_shutdown_first: assert property (
    @(posedge sys_clk) disable iff (rst)
    func[FN_SHUT_LSB + 3] |-> !pinIsOut[3] && (shutdownReq[3] == pinLevel[3]) && !serClkIn)
    else $error("pin A3 not a shutdown input");
  a_a3_clock_out: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!func[FN_SHUT_LSB + 3] && !func[FN_CKIN] && func[FN_CKOUT])
      |-> pinIsOut[3] && (pinOutVal[3] == serClkOut))
    else $error("pin A3 not driving the serial clock");
  a_a2_receive: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!func[FN_SHUT_LSB + 2] && func[FN_RXON]) |-> !pinIsOut[2] && (serRxData == pinLevel[2]))
    else $error("pin A2 not the receive input");
  a_a1_transmit: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!func[FN_SHUT_LSB + 1] && func[FN_TXON]) |-> pinIsOut[1] && (pinOutVal[1] == serTxData))
    else $error("pin A1 not the transmit output");
  a_a0_plain_io: assert property (
    @(posedge sys_clk) disable iff (rst)
    !func[FN_SHUT_LSB] |-> (pinIsOut[0] == dir[0]) && !shutdownReq[0])
    else $error("pin A0 direction not followed");

endmodule : port_a_mux
`default_nettype wire

// File: core/gpio_ports_ab.sv
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Open-drain output also forces pull-up off
// - Drain bit zero gives push-pull output
// - Drain register: four bits, reset zero
// - A3: shutdown, clock in, clock out, GPIO
// - A2: shutdown, receive input, GPIO
// - A1: shutdown, transmit output, GPIO
// - A0: shutdown input or GPIO
// - Port B direction one means output
// - Port B direction is write only
// - Port B output data, eight bits, reset zero
// - Port B level: data if output, else pin
// - Port B level read only, shows data or pin per direction
// - Port A level: data if output, else pin
// - Pull-up bit turns on input pull-up
module gpio_ports_ab
  import gpio_ab_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [DATA_W-1:0] hwdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [DATA_W-1:0] hrdata,
  // Serial channel 2 side
  input  wire logic              serTxData,
  input  wire logic              serClkOut,
  output logic                   serRxData,
  output logic                   serClkIn,
  // Output shutdown requests
  output logic      [PA_W-1:0]   shutdownReq,
  // Port A pins
  input  wire logic [PA_W-1:0]   paIn,
  output logic      [PA_W-1:0]   paOut,
  output logic      [PA_W-1:0]   paOe,
  output logic      [PA_W-1:0]   paPullup,
  // Port B pins
  input  wire logic [PB_W-1:0]   pbIn,
  output logic      [PB_W-1:0]   pbOut,
  output logic      [PB_W-1:0]   pbOe
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Control registers
  logic [PA_W-1:0] paDir;                                 // port_a_direction
  logic [PA_W-1:0] paData;                                // port_a_output_data
  logic [PA_W-1:0] paPull;                                // port_a_pullup_ctrl
  logic [PA_W-1:0] paDrain;                               // port_a_drain_type
  logic [FN_W-1:0] paFunc;                                // Pin function select
  logic [PB_W-1:0] pbDir;                                 // port_b_direction
  logic [PB_W-1:0] pbData;                                // port_b_output_data

  // Next values, including a write finishing this cycle
  logic [PA_W-1:0] next_paDir;
  logic [PA_W-1:0] next_paData;
  logic [PA_W-1:0] next_paPull;
  logic [PA_W-1:0] next_paDrain;
  logic [FN_W-1:0] next_paFunc;
  logic [PB_W-1:0] next_pbDir;
  logic [PB_W-1:0] next_pbData;

  // Bus pipeline
  logic              addrTaken;                           // Valid address phase seen now
  logic              wrPending;                           // Write data phase in progress
  logic [ADDR_W-1:0] wrAddr;                              // Address held for the write

  // Filtered pin levels
  logic [PA_W-1:0] paLevel;
  logic [PB_W-1:0] pbLevel;

  // Port A function outputs
  logic [PA_W-1:0] paIsOut;                               // Pin is an output of any kind
  logic [PA_W-1:0] paOutVal;                              // Level to present when driving

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Word match on the decoded index bits; used by both read and write decode
  function automatic logic hitReg(input logic [ADDR_W-1:0] a, input logic [31:0] ofs);
    hitReg = (a[IDX_LSB +: REG_IDX_W] == ofs[IDX_LSB +: REG_IDX_W])
             && (a[ADDR_W-1:IDX_LSB + REG_IDX_W] == '0);
  endfunction : hitReg

  // Output register when driving, pin otherwise
  function automatic logic [PB_W-1:0] levelView(input logic [PB_W-1:0] d,
                                                input logic [PB_W-1:0] q,
                                                input logic [PB_W-1:0] p);
    levelView = (d & q) | (~d & p);
  endfunction : levelView

  ////////////////////////////////////////////////////////////////////////////
  // Pin samplers

  // Port A pins come from the board, so they cross into this clock
  pin_sync #(
    .W (PA_W)
  ) u_sync_a (
    .sys_clk  (sys_clk),
    .pinRaw   (paIn),
    .pinLevel (paLevel)
  );

  // Port B pins likewise
  pin_sync #(
    .W (PB_W)
  ) u_sync_b (
    .sys_clk  (sys_clk),
    .pinRaw   (pbIn),
    .pinLevel (pbLevel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave

  // Zero wait states, always OKAY; hsize is ignored since only words are used
  assign hreadyout = 1'b1;
  assign hresp     = RESP_OKAY;
  assign addrTaken = hsel && htrans[1] && hready;

  // Hold the write address into the data phase
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrPending <= 1'b0;
      wrAddr    <= '0;
    end else if (hready) begin
      wrPending <= addrTaken && hwrite;
      wrAddr    <= haddr;
    end
  end

  // Next register values; a write lands at the end of its data phase
  always_comb begin
    next_paDir   = paDir;
    next_paData  = paData;
    next_paPull  = paPull;
    next_paDrain = paDrain;
    next_paFunc  = paFunc;
    next_pbDir   = pbDir;
    next_pbData  = pbData;
    if (wrPending) begin
      // Level registers have no branch here, so writes to them vanish
      if (hitReg(wrAddr, OFS_PA_DIR)) begin
        next_paDir = hwdata[PA_W-1:0];
      end
      if (hitReg(wrAddr, OFS_PA_DATA)) begin
        next_paData = hwdata[PA_W-1:0];
      end
      if (hitReg(wrAddr, OFS_PA_PULL)) begin
        next_paPull = hwdata[PA_W-1:0];
      end
      if (hitReg(wrAddr, OFS_PA_DRAIN)) begin
        next_paDrain = hwdata[PA_W-1:0];
      end
      if (hitReg(wrAddr, OFS_PA_FUNC)) begin
        next_paFunc = hwdata[FN_W-1:0];
      end
      if (hitReg(wrAddr, OFS_PB_DIR)) begin
        next_pbDir = hwdata[PB_W-1:0];
      end
      if (hitReg(wrAddr, OFS_PB_DATA)) begin
        next_pbData = hwdata[PB_W-1:0];
      end
    end
  end

  // Port A control registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      paDir   <= PA_RESET;
      paData  <= PA_RESET;
      paPull  <= PA_RESET;
      paDrain <= PA_RESET;
      paFunc  <= FN_RESET;
    end else begin
      paDir   <= next_paDir;
      paData  <= next_paData;
      paPull  <= next_paPull;
      paDrain <= next_paDrain;
      paFunc  <= next_paFunc;
    end
  end

  // Port B control registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pbDir  <= PB_RESET;
      pbData <= PB_RESET;
    end else begin
      pbDir  <= next_pbDir;
      pbData <= next_pbData;
    end
  end

  // Read data is latched at the address phase from next values, so a read that
  // directly follows a write already sees the written word
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hrdata <= RD_ZERO;
    end else if (hready) begin
      hrdata <= RD_ZERO;                                  // Unmapped, reserved, write only
      if (addrTaken && !hwrite) begin
        if (hitReg(haddr, OFS_PA_DATA)) begin
          hrdata[PA_W-1:0] <= next_paData;
        end
        if (hitReg(haddr, OFS_PA_LEVEL)) begin
          hrdata[PA_W-1:0] <= (next_paDir & next_paData) | (~next_paDir & paLevel);
        end
        if (hitReg(haddr, OFS_PA_PULL)) begin
          hrdata[PA_W-1:0] <= next_paPull;
        end
        if (hitReg(haddr, OFS_PA_DRAIN)) begin
          hrdata[PA_W-1:0] <= next_paDrain;
        end
        if (hitReg(haddr, OFS_PA_FUNC)) begin
          hrdata[FN_W-1:0] <= next_paFunc;
        end
        if (hitReg(haddr, OFS_PB_DATA)) begin
          hrdata[PB_W-1:0] <= next_pbData;
        end
        if (hitReg(haddr, OFS_PB_LEVEL)) begin
          hrdata[PB_W-1:0] <= levelView(next_pbDir, next_pbData, pbLevel);
        end
        // Direction registers fall through to zero
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port A pin logic

  // Function selection per pin
  port_a_mux u_mux (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .dir         (paDir),
    .outData     (paData),
    .func        (paFunc),
    .serTxData   (serTxData),
    .serClkOut   (serClkOut),
    .serRxData   (serRxData),
    .serClkIn    (serClkIn),
    .shutdownReq (shutdownReq),
    .pinLevel    (paLevel),
    .pinIsOut    (paIsOut),
    .pinOutVal   (paOutVal)
  );

  // Output stage; open drain also covers serial outputs on the same pin
  always_comb begin
    for (int i = 0; i < PA_W; i++) begin
      if (!paIsOut[i]) begin
        paOut[i]    = 1'b0;
        paOe[i]     = 1'b0;
        paPullup[i] = paPull[i];
      end else if (paDrain[i]) begin
        paOut[i]    = 1'b0;
        paOe[i]     = !paOutVal[i];
        paPullup[i] = 1'b0;
      end else begin
        paOut[i]    = paOutVal[i];
        paOe[i]     = 1'b1;
        paPullup[i] = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port B pin logic

  // Direction straight from the register; pull-up and open drain not here
  assign pbOut = pbData;
  assign pbOe  = pbDir;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_od_low_release: assert property (
    @(posedge sys_clk) disable iff (rst)
    (paIsOut[0] && paDrain[0]) |-> (paOe[0] == !paOutVal[0]) && !paOut[0] && !paPullup[0])
    else $error("open drain pin A0 drives wrong");
  a_pp_drive_level: assert property (
    @(posedge sys_clk) disable iff (rst)
    (paIsOut[1] && !paDrain[1]) |-> paOe[1] && (paOut[1] == paOutVal[1]))
    else $error("push-pull pin A1 drives wrong");
  a_pull_input_only: assert property (
    @(posedge sys_clk) disable iff (rst)
    paPullup[2] |-> paPull[2] && !paIsOut[2])
    else $error("pull-up on while pin A2 is not an input");
  a_drain_write_lands: assert property (
    @(posedge sys_clk) disable iff (rst)
    (addrTaken && hwrite && hitReg(haddr, OFS_PA_DRAIN))
      |=> ##1 (paDrain == $past(hwdata[PA_W-1:0])))
    else $error("open-drain control write lost");
  a_pbdir_reads_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    (addrTaken && !hwrite && hitReg(haddr, OFS_PB_DIR)) |=> (hrdata == RD_ZERO))
    else $error("port B direction readable");
  a_pb_level_view: assert property (
    @(posedge sys_clk) disable iff (rst)
    (addrTaken && !hwrite && !wrPending && hitReg(haddr, OFS_PB_LEVEL))
      |=> (hrdata[PB_W-1:0] == levelView($past(pbDir), $past(pbData), $past(pbLevel))))
    else $error("port B level read wrong");
  a_pb_level_no_write: assert property (
    @(posedge sys_clk) disable iff (rst)
    (addrTaken && hwrite && hitReg(haddr, OFS_PB_LEVEL)) |-> ##2 $stable(pbDir) && $stable(pbData))
    else $error("write to port B level changed state");
  a_pb_oe_follows: assert property (
    @(posedge sys_clk) disable iff (rst)
    (wrPending && hitReg(wrAddr, OFS_PB_DIR)) |=> (pbOe == $past(hwdata[PB_W-1:0])))
    else $error("port B output enable not following direction");

  // The port A pin checks above watch sample pins; the ones below cover whole ports
  // Port A level read, mirror of the port B check
  a_pa_level_view: assert property (
    @(posedge sys_clk) disable iff (rst)
    (addrTaken && !hwrite && !wrPending && hitReg(haddr, OFS_PA_LEVEL))
      |=> (hrdata[PA_W-1:0] == (($past(paDir) & $past(paData))
                                | (~$past(paDir) & $past(paLevel)))))
    else $error("port A level read wrong");
  // Port B output data reaches the pins one edge after the write
  a_pbdata_lands: assert property (
    @(posedge sys_clk) disable iff (rst)
    (wrPending && hitReg(wrAddr, OFS_PB_DATA)) |=> (pbOut == $past(hwdata[PB_W-1:0])))
    else $error("port B output data write lost");
  // Control state is clear on the first edge after reset; not disabled by reset itself
  a_reset_clears: assert property (
    @(posedge sys_clk)
    $fell(rst) |-> (paDrain == PA_RESET) && (pbDir == PB_RESET) && (pbData == PB_RESET))
    else $error("control registers not cleared by reset");
  // Every open-drain output on port A: low drive only, pull-up off
  a_od_pullup_off: assert property (
    @(posedge sys_clk) disable iff (rst)
    ((paIsOut & paDrain & (paPullup | paOut)) == '0))
    else $error("open-drain pin with pull-up or high drive");
  // Inputs never drive, and their pull-up follows the control bit
  a_input_no_drive: assert property (
    @(posedge sys_clk) disable iff (rst)
    ((~paIsOut & (paOe | (paPullup ^ paPull))) == '0))
    else $error("input pin driving or pull-up wrong");

endmodule : gpio_ports_ab
`default_nettype wire

// File: bench/board_pins.sv
`timescale 1ns/10ps
`default_nettype none
// Board side of both ports: a driving device pin wins, else the board source
module board_pins
  import gpio_ab_pkg::*;
(
  // Port A from the device
  input  wire logic [PA_W-1:0] paOut,
  input  wire logic [PA_W-1:0] paOe,
  // Port B from the device
  input  wire logic [PB_W-1:0] pbOut,
  input  wire logic [PB_W-1:0] pbOe,
  // Board sources
  input  wire logic [PA_W-1:0] extA,
  input  wire logic [PB_W-1:0] extB,
  // Levels seen at the pins
  output logic      [PA_W-1:0] paIn,
  output logic      [PB_W-1:0] pbIn
);
  ////////////////////////////////////////////////////////////////////////////
  // Per-bit resolution; open-drain release shows the board level
  assign paIn = (paOe & paOut) | (~paOe & extA);
  assign pbIn = (pbOe & pbOut) | (~pbOe & extB);
endmodule : board_pins
`default_nettype wire

// File: bench/gpio_ports_a_b_pin_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
// Register-level bench for the two ports
module gpio_ports_a_b_pin_control_tb;
  import gpio_ab_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
  logic [1:0] htrans = 2'b00;
  logic hreadyout, hresp, serTxData = 1'b0, serClkOut = 1'b0, serRxData, serClkIn;
  logic [3:0] shutdownReq, paIn, paOut, paOe, paPullup, extA = 4'hA;
  logic [7:0] pbIn, pbOut, pbOe, extB = 8'h03;
  int miscompares = 0, total_checks = 0;
  assign hready = hreadyout; // Single slave drives the bus ready
  always #4 sys_clk = ~sys_clk;
  gpio_ports_ab uut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hready), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serTxData(serTxData),
    .serClkOut(serClkOut), .serRxData(serRxData), .serClkIn(serClkIn),
    .shutdownReq(shutdownReq), .paIn(paIn), .paOut(paOut), .paOe(paOe),
    .paPullup(paPullup), .pbIn(pbIn), .pbOut(pbOut), .pbOe(pbOe));
  board_pins board (.paOut(paOut), .paOe(paOe), .pbOut(pbOut), .pbOe(pbOe),
    .extA(extA), .extB(extB), .paIn(paIn), .pbIn(pbIn));
  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  // Compare seen against expected
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Wait for ready under a bound; a hang ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      test_done();
    end
  endtask : wait_rdy
  // One single AHB transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    r = hrdata; // Read data taken at the data phase edge
    #1;
  endtask : xfer
  // Let the pin samplers settle, edge aligned
  task automatic settle;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask : settle
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    xfer(0, OFS_PA_DRAIN, 0); chk(r, 0);
    chk({hreadyout, hresp}, 2'b10);
    xfer(0, OFS_PB_DATA, 0); chk(r, 0);
    chk({paOe, pbOe}, 0);
    xfer(1, OFS_PA_DRAIN, 32'hFF); xfer(0, OFS_PA_DRAIN, 0); chk(r, 32'h0F);
    $display("reset and drain register done");
    // Port B direction, data, level
    xfer(1, OFS_PB_DIR, 32'hF0); xfer(1, OFS_PB_DATA, 32'hA5);
    chk({pbOe, pbOut}, 16'hF0A5);
    xfer(0, OFS_PB_DIR, 0); chk(r, 0);
    xfer(0, OFS_PB_DATA, 0); chk(r, 32'hA5);
    settle(); xfer(0, OFS_PB_LEVEL, 0); chk(r, 32'hA3);
    xfer(1, OFS_PB_LEVEL, 32'hFF); xfer(0, OFS_PB_LEVEL, 0); chk(r, 32'hA3);
    xfer(1, 32'h40, 32'h11); xfer(0, 32'h40, 0); chk(r, 0);
    $display("port B done");
    // Port A push-pull then open-drain with pull-ups requested
    xfer(1, OFS_PA_PULL, 4'hF); xfer(1, OFS_PA_DATA, 4'h5);
    xfer(1, OFS_PA_DRAIN, 0); xfer(1, OFS_PA_DIR, 4'hF);
    chk({paOe, paOut, paPullup}, 12'hF50);
    xfer(0, OFS_PA_LEVEL, 0); chk(r, 4'h5);
    xfer(1, OFS_PA_DRAIN, 4'hF);
    chk({paOe, paOut, paPullup}, 12'hA00);
    xfer(1, OFS_PA_DIR, 0); chk({paOe, paPullup}, 8'h0F);
    settle(); xfer(0, OFS_PA_LEVEL, 0); chk(r, 4'hA);
    $display("port A direction and drain done");
    // Pin functions: shutdown overrides an output direction
    xfer(1, OFS_PA_DIR, 4'hF); xfer(1, OFS_PA_FUNC, 9'h00F);
    settle(); chk({paOe, shutdownReq}, 8'h0A);
    xfer(1, OFS_PA_FUNC, 9'h080); settle();
    chk({paOe[2], serRxData}, 2'b00);
    xfer(1, OFS_PA_FUNC, 9'h100); xfer(1, OFS_PA_DATA, 4'hF);
    chk({paOe[1], paOut[1]}, 2'b10);
    chk(serRxData, 1'b1);
    serTxData <= 1'b1; #1; chk(paOe[1], 1'b0);
    xfer(1, OFS_PA_DIR, 0); xfer(1, OFS_PA_FUNC, 9'h010); settle();
    chk({paOe[3], serClkIn}, 2'b01);
    xfer(1, OFS_PA_DRAIN, 0); serClkOut <= 1'b1;
    xfer(1, OFS_PA_FUNC, 9'h020); chk({paOe[3], paOut[3]}, 2'b11);
    xfer(1, OFS_PA_FUNC, 9'h040); chk({paOe[3], paOut[3]}, 2'b11);
    xfer(1, OFS_PA_FUNC, 9'h018); chk({paOe[3], serClkIn, shutdownReq[3]}, 3'b001);
    $display("pin functions done");
    test_done();
  end
endmodule : gpio_ports_a_b_pin_control_tb
`default_nettype wire
